// ---- rtl/cmbm_top.sv ----
/*
 Message storage of a CAN controller: two-stage receive queue, three
 prioritised transmit buffers with abort, AXI4-Lite register slave.
 Assumes the protocol engine runs on clk_in and drives eng_in synchronously.
*/
// The AXI4-Lite slave port and the register addresses were left to the implementer.
// Overview of operation
// - Received frames go to a back stage, then a host-readable front stage.
// - Each receive stage holds 13 bytes: control, identifier and data.
// - Receive-full flag marks an accepted, correctly received frame in the front stage.
// - Incoming bytes are written to the back stage while filtering runs.
// - An accepted frame moves to the front stage only when receive-full is clear.
// - The back stage accepts a new frame right after the interframe space.
// - The back stage is overwritten on every reception, accepted or not, except while it holds a waiting frame.
// - Receive interrupt needs its enable; the flag stays pollable when masked.
// - Own frames reach only the back stage; no interrupt, no acknowledge.
// - In loop-back own frames are handled like any received frame.
// - After losing arbitration the device becomes a receiver.
// - Accepted frame with both stages full is discarded and flags overrun.
// - With both stages full, transmission continues and incoming frames are dropped.
// - Three transmit buffers of 13 bytes each, with an 8-bit local priority.
// - Successful sending sets the empty flag; transmit interrupt if unmasked.
// - Among scheduled buffers the lowest local priority value wins.
// - Buffer selection reruns at every arbitration, also after an error.
// - Abort request frees a buffer not on the bus, with acknowledge.
// - Abort acknowledge reads 1 when aborted, 0 when sent meanwhile.
// - With more buffers scheduled, the next arbitration follows without releasing the bus.
// - Flags clear on writing 1; writing 0 leaves them.
// - A clear is ignored while the setting condition still holds.
// - Receive interrupt rises right after the end of an accepted frame.
`timescale 1ns/10ps
module cmbm_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire cmbm_pkg::cmbm_axi_req_t axi_in,
	output cmbm_pkg::cmbm_axi_rsp_t axi_out,
	input wire cmbm_pkg::cmbm_eng_in_t eng_in,
	output cmbm_pkg::cmbm_eng_out_t eng_out
);
	import cmbm_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] byte_of(logic [31:0] w, logic [1:0] i);
		return w[{i, 3'b000} +: 8];
	endfunction

	function automatic logic [31:0] stage_word(logic [MSG_BYTES-1:0][7:0] st, logic [1:0] w);
		logic [127:0] f;
		f = {24'h0, st};
		return f[{w, 5'b00000} +: 32];
	endfunction

	function automatic logic is_txbuf(logic [7:0] a);
		return a[7:6] == A_TXBUF[7:6] && a[5:4] != 2'h3 && a[1:0] == 2'h0;
	endfunction

	function automatic logic is_local_priority_field(logic [7:0] a);
		return a[7:4] == A_PRIO0[7:4] && a[3:2] != 2'h3 && a[1:0] == 2'h0;
	endfunction

	function automatic logic is_front(logic [7:0] a);
		return a[7:4] == A_FRONT[7:4] && a[1:0] == 2'h0;
	endfunction

	// ==========================================================
	// State and combinational signals
	cmbm_state_t s_ff;
	cmbm_state_t nxt_s;
	logic [31:0] mem_a;
	logic [31:0] mem_b;
	logic mem_we;
	logic [3:0] mem_wstrb;
	logic [NBUF-1:0] pend;
	logic sel_any;
	logic [1:0] sel_idx;
	logic wr_go;
	logic [1:0] clr_rx;
	logic [NBUF-1:0] clr_txe;
	logic [NBUF-1:0] set_abrq;
	logic loop_on;
	logic own_frame;
	logic rx_acc;
	logic [31:0] rd_data;
	logic rd_ok;

	assign axi_out = '{awready: s_ff.aw_free, wready: s_ff.w_free, bvalid: s_ff.bvalid,
		bresp: s_ff.bresp, arready: s_ff.ar_free, rvalid: s_ff.rvalid,
		rdata: s_ff.rdata, rresp: s_ff.rresp};
	assign eng_out = s_ff.eo;
	assign pend = ~s_ff.transmit_empty_flag & ~s_ff.abrq;
	assign loop_on = s_ff.ctrl[C_LOOP];
	assign own_frame = eng_in.rx_own && !loop_on;
	assign rx_acc = eng_in.rx_end && eng_in.rx_hit && !own_frame;

	cmbm_txmem u_mem (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.wr_en_in(mem_we),
		.wr_idx_in(s_ff.aw_addr[5:2]),
		.wstrb_in(mem_wstrb),
		.wdata_in(s_ff.wdata),
		.rda_idx_in({s_ff.cur, eng_in.tx_idx[3:2]}),
		.rdb_idx_in(axi_in.araddr[5:2]),
		.rda_out(mem_a),
		.rdb_out(mem_b)
	);

	cmbm_local_priority_field_sel u_sel (
		.pend_in(pend),
		.local_priority_field_in(s_ff.local_priority_field),
		.any_out(sel_any),
		.sel_out(sel_idx)
	);

	// ==========================================================
	// Register read decode
	always_comb begin
		rd_data = 32'h0;
		rd_ok = 1'b1;
		if (is_txbuf(axi_in.araddr)) begin
			rd_data = mem_b;
		end else if (is_front(axi_in.araddr)) begin
			rd_data = stage_word(s_ff.front, axi_in.araddr[3:2]);
		end else if (is_local_priority_field(axi_in.araddr)) begin
			rd_data[7:0] = s_ff.local_priority_field[axi_in.araddr[3:2]];
		end else begin
			case (axi_in.araddr)
				A_CTRL: rd_data[7:0] = s_ff.ctrl;
				A_RXFLG: begin
					rd_data[F_RXF] = s_ff.receive_full_flag;
					rd_data[F_OVR] = s_ff.ovr;
				end
				A_TXFLG: begin
					rd_data[NBUF-1:0] = s_ff.transmit_empty_flag;
					rd_data[F_ABAK +: NBUF] = s_ff.abak;
				end
				A_TXCTL: rd_data[NBUF-1:0] = s_ff.abrq;
				A_STAT: rd_data[4:0] = {s_ff.cur, s_ff.tx_act, s_ff.bg_hold, s_ff.receive_full_flag};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		nxt_s = s_ff;
		mem_we = 1'b0;
		mem_wstrb = 4'h0;
		clr_rx = 2'h0;
		clr_txe = '0;
		set_abrq = '0;
		wr_go = !s_ff.aw_free && !s_ff.w_free && !s_ff.bvalid;

		// Write channel: address and data taken in either order
		if (s_ff.aw_free && axi_in.awvalid) begin
			nxt_s.aw_free = 1'b0;
			nxt_s.aw_addr = axi_in.awaddr;
		end
		if (s_ff.w_free && axi_in.wvalid) begin
			nxt_s.w_free = 1'b0;
			nxt_s.wdata = axi_in.wdata;
			nxt_s.wstrb = axi_in.wstrb;
		end
		if (s_ff.bvalid && axi_in.bready) begin
			nxt_s.bvalid = 1'b0;
			nxt_s.aw_free = 1'b1;
			nxt_s.w_free = 1'b1;
		end
		if (wr_go) begin
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			if (is_txbuf(s_ff.aw_addr)) begin
				mem_we = 1'b1;
				// Last word carries only byte 12; upper lanes stay zero
				mem_wstrb = (s_ff.aw_addr[3:2] == 2'h3) ? (s_ff.wstrb & 4'h1) : s_ff.wstrb;
			end else if (is_local_priority_field(s_ff.aw_addr)) begin
				if (s_ff.wstrb[0]) begin
					nxt_s.local_priority_field[s_ff.aw_addr[3:2]] = s_ff.wdata[7:0];
				end
			end else if (s_ff.aw_addr == A_CTRL) begin
				if (s_ff.wstrb[0]) begin
					nxt_s.ctrl = s_ff.wdata[7:0];
				end
			end else if (s_ff.aw_addr == A_RXFLG) begin
				clr_rx = s_ff.wstrb[0] ? s_ff.wdata[1:0] : 2'h0;
			end else if (s_ff.aw_addr == A_TXFLG) begin
				clr_txe = s_ff.wstrb[0] ? s_ff.wdata[NBUF-1:0] : '0;
			end else if (s_ff.aw_addr == A_TXCTL) begin
				set_abrq = s_ff.wstrb[0] ? s_ff.wdata[NBUF-1:0] : '0;
			end else if (s_ff.aw_addr != A_STAT && !is_front(s_ff.aw_addr)) begin
				nxt_s.bresp = RESP_SLVERR;
			end
		end

		// Read channel
		if (s_ff.rd_st == RD_RESP && axi_in.rready) begin
			nxt_s.rd_st = RD_IDLE;
			nxt_s.rvalid = 1'b0;
			nxt_s.ar_free = 1'b1;
		end
		if (s_ff.ar_free && axi_in.arvalid) begin
			nxt_s.rd_st = RD_RESP;
			nxt_s.rvalid = 1'b1;
			nxt_s.ar_free = 1'b0;
			nxt_s.rdata = rd_data;
			nxt_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// Receive: host side clears first, engine events win afterwards
		if (clr_rx[F_RXF] && s_ff.receive_full_flag) begin
			if (s_ff.bg_hold) begin
				nxt_s.front = s_ff.back;
				nxt_s.bg_hold = 1'b0;
			end else begin
				nxt_s.receive_full_flag = 1'b0;
			end
		end
		if (clr_rx[F_OVR]) begin
			nxt_s.ovr = 1'b0;
		end
		// A held message freezes the back stage, else every frame lands there
		if (eng_in.rx_wr && !s_ff.bg_hold && eng_in.rx_idx < MSG_BYTES) begin
			nxt_s.back[eng_in.rx_idx] = eng_in.rx_byte;
		end
		if (rx_acc) begin
			if (s_ff.bg_hold) begin
				nxt_s.ovr = 1'b1;
			end else if (!nxt_s.receive_full_flag) begin
				nxt_s.front = nxt_s.back;
				nxt_s.receive_full_flag = 1'b1;
			end else begin
				nxt_s.bg_hold = 1'b1;
			end
		end

		// Transmit: scheduling by clearing the empty flag
		for (int b = 0; b < NBUF; b++) begin
			if (clr_txe[b] && s_ff.transmit_empty_flag[b]) begin
				nxt_s.transmit_empty_flag[b] = 1'b0;
				nxt_s.abak[b] = 1'b0;
			end
			if (set_abrq[b] && !nxt_s.transmit_empty_flag[b]) begin
				nxt_s.abrq[b] = 1'b1;
			end
			// A frame on the bus cannot be aborted
			if (s_ff.abrq[b] && !(s_ff.tx_act && s_ff.cur == 2'(b))) begin
				nxt_s.transmit_empty_flag[b] = 1'b1;
				nxt_s.abak[b] = 1'b1;
				nxt_s.abrq[b] = 1'b0;
			end
		end
		if (eng_in.tx_ok && s_ff.tx_act) begin
			nxt_s.transmit_empty_flag[s_ff.cur] = 1'b1;
			nxt_s.abak[s_ff.cur] = 1'b0;
			nxt_s.abrq[s_ff.cur] = 1'b0;
			nxt_s.tx_act = 1'b0;
		end else if (eng_in.tx_fail) begin
			nxt_s.tx_act = 1'b0;
		end
		if (eng_in.arb_start && !s_ff.tx_act && sel_any) begin
			nxt_s.tx_act = 1'b1;
			nxt_s.cur = sel_idx;
		end

		// Engine outputs, all registered
		nxt_s.eo.tx_pend = |(~nxt_s.transmit_empty_flag & ~nxt_s.abrq);
		nxt_s.eo.tx_go = nxt_s.tx_act;
		nxt_s.eo.tx_sel = nxt_s.cur;
		nxt_s.eo.tx_byte = byte_of(mem_a, eng_in.tx_idx[1:0]);
		nxt_s.eo.ack_allow = !(nxt_s.tx_act && !loop_on);
		nxt_s.eo.rx_irq = nxt_s.receive_full_flag && nxt_s.ctrl[C_RXIE];
		nxt_s.eo.err_irq = nxt_s.ovr && nxt_s.ctrl[C_OVRIE];
		nxt_s.eo.tx_irq = |(nxt_s.transmit_empty_flag & nxt_s.ctrl[C_TXIE +: NBUF]);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_ff <= ST_RST;
		end else if (ce_in) begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// Checks
	rxf_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && rx_acc && !s_ff.receive_full_flag && !s_ff.bg_hold |=> s_ff.receive_full_flag && !s_ff.bg_hold)
		else $error("accepted frame did not reach front stage");
	ovr_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && rx_acc && s_ff.bg_hold |=> s_ff.ovr && s_ff.receive_full_flag)
		else $error("overrun not flagged");
	own_frame_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && eng_in.rx_end && own_frame && !s_ff.receive_full_flag |=> !s_ff.receive_full_flag && !eng_out.rx_irq)
		else $error("own frame reached front stage");
	rx_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!s_ff.ctrl[C_RXIE] |-> !eng_out.rx_irq)
		else $error("masked receive interrupt raised");
	txe_done_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && eng_in.tx_ok && s_ff.tx_act |=> s_ff.transmit_empty_flag[$past(s_ff.cur)] && !s_ff.tx_act)
		else $error("empty flag not set after send");
	abort_grant_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && s_ff.abrq[0] && !(s_ff.tx_act && s_ff.cur == 2'h0)
		|=> s_ff.transmit_empty_flag[0] && s_ff.abak[0] && !s_ff.abrq[0])
		else $error("abort not granted");
	local_priority_field_pick_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sel_any |-> (!pend[0] || s_ff.local_priority_field[sel_idx] <= s_ff.local_priority_field[0])
		&& (!pend[1] || s_ff.local_priority_field[sel_idx] <= s_ff.local_priority_field[1])
		&& (!pend[2] || s_ff.local_priority_field[sel_idx] <= s_ff.local_priority_field[2]))
		else $error("wrong transmit buffer chosen");
	back_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && s_ff.bg_hold && !clr_rx[F_RXF] |=> $stable(s_ff.back) && s_ff.bg_hold)
		else $error("held back stage changed");
	// Interrupt outputs are registered with the flag, so both are seen at one edge
	rx_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && rx_acc && !s_ff.receive_full_flag && !s_ff.bg_hold |=> eng_out.rx_irq == s_ff.ctrl[C_RXIE])
		else $error("receive interrupt not raised after frame");
	loop_own_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && loop_on && eng_in.rx_end && eng_in.rx_hit && eng_in.rx_own && !s_ff.receive_full_flag
		&& !s_ff.bg_hold |=> s_ff.receive_full_flag)
		else $error("loop-back frame not delivered");
	clr_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && clr_rx[F_RXF] && s_ff.receive_full_flag && s_ff.bg_hold |=> s_ff.receive_full_flag && !s_ff.bg_hold)
		else $error("waiting message not pulled forward");
	back_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && eng_in.rx_wr && !s_ff.bg_hold && eng_in.rx_idx < MSG_BYTES
		|=> s_ff.back[$past(eng_in.rx_idx)] == $past(eng_in.rx_byte))
		else $error("received byte not stored");
	tx_sched_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && clr_txe[0] && s_ff.transmit_empty_flag[0] |=> !s_ff.transmit_empty_flag[0])
		else $error("empty flag not cleared");
	tx_go_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && eng_in.arb_start && !s_ff.tx_act && sel_any
		|=> eng_out.tx_go && eng_out.tx_sel == $past(sel_idx))
		else $error("selected buffer not handed to engine");
	ack_own_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && s_ff.tx_act && !loop_on && !eng_in.tx_ok && !eng_in.tx_fail
		|=> !eng_out.ack_allow)
		else $error("own frame acknowledged");
	tx_retry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && eng_in.tx_fail && !eng_in.tx_ok && s_ff.tx_act
		|=> !s_ff.tx_act && !s_ff.transmit_empty_flag[$past(s_ff.cur)])
		else $error("failed buffer not kept scheduled");
	abort_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && s_ff.tx_act && s_ff.abrq[s_ff.cur] && !eng_in.tx_ok && !eng_in.tx_fail
		|=> s_ff.tx_act && !s_ff.transmit_empty_flag[s_ff.cur])
		else $error("frame on the bus aborted");
	abak_sent_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && eng_in.tx_ok && s_ff.tx_act
		|=> !s_ff.abak[$past(s_ff.cur)] && !s_ff.abrq[$past(s_ff.cur)])
		else $error("sent buffer shows abort");
endmodule // cmbm_top

// ---- rtl/cmbm_pkg.sv ----
/*
 Shared constants and types of the CAN message buffer manager.
 Assumes a single clock domain and an AXI4-Lite master with 8-bit addresses.
*/
package cmbm_pkg;
	// ==========================================================
	// Sizes and register map
	localparam int NBUF = 3;
	localparam int MSG_BYTES = 13;
	localparam int MEM_WORDS = 12;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_RXFLG = 8'h04;
	localparam logic [7:0] A_TXFLG = 8'h08;
	localparam logic [7:0] A_TXCTL = 8'h0c;
	localparam logic [7:0] A_PRIO0 = 8'h10;
	localparam logic [7:0] A_STAT = 8'h1c;
	localparam logic [7:0] A_FRONT = 8'h40;
	localparam logic [7:0] A_TXBUF = 8'h80;
	// ==========================================================
	// Field positions and reset values
	localparam int C_LOOP = 0;
	localparam int C_RXIE = 1;
	localparam int C_OVRIE = 2;
	localparam int C_TXIE = 4;
	localparam int F_RXF = 0;
	localparam int F_OVR = 1;
	localparam int F_ABAK = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] LOCAL_PRIORITY_FIELD_RST = 8'h00;
	localparam logic [NBUF-1:0] TXE_RST = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Types
	typedef enum logic [0:0] {RD_IDLE, RD_RESP} cmbm_rd_st_t;
	typedef struct packed {
		logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
		logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
	} cmbm_axi_req_t;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} cmbm_axi_rsp_t;
	typedef struct packed {
		logic rx_wr; logic [3:0] rx_idx; logic [7:0] rx_byte; logic rx_end;
		logic rx_hit; logic rx_own; logic arb_start; logic tx_ok; logic tx_fail;
		logic [3:0] tx_idx;
	} cmbm_eng_in_t;
	typedef struct packed {
		logic tx_pend; logic tx_go; logic [1:0] tx_sel; logic [7:0] tx_byte;
		logic ack_allow; logic rx_irq; logic tx_irq; logic err_irq;
	} cmbm_eng_out_t;
	typedef struct packed {
		logic aw_free; logic w_free; logic [7:0] aw_addr; logic [31:0] wdata;
		logic [3:0] wstrb; logic bvalid; logic [1:0] bresp;
		cmbm_rd_st_t rd_st; logic ar_free; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
		logic [7:0] ctrl; logic [NBUF-1:0][7:0] local_priority_field; logic receive_full_flag; logic ovr; logic bg_hold;
		logic [NBUF-1:0] transmit_empty_flag; logic [NBUF-1:0] abak; logic [NBUF-1:0] abrq;
		logic tx_act; logic [1:0] cur;
		logic [MSG_BYTES-1:0][7:0] front; logic [MSG_BYTES-1:0][7:0] back;
		cmbm_eng_out_t eo;
	} cmbm_state_t;
	typedef struct packed {
		logic [MEM_WORDS-1:0][31:0] word;
	} cmbm_mem_t;
	localparam cmbm_state_t ST_RST = '{aw_free: 1'b1, w_free: 1'b1, ar_free: 1'b1,
		rd_st: RD_IDLE, ctrl: CTRL_RST, local_priority_field: {NBUF{LOCAL_PRIORITY_FIELD_RST}}, transmit_empty_flag: TXE_RST, default: '0};
endpackage

// ---- rtl/cmbm_txmem.sv ----
/*
 Storage of the three transmit buffers, four words each.
 Assumes the caller only writes legal word indices and masks reserved bytes.
*/
`timescale 1ns/10ps
module cmbm_txmem (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [3:0] wr_idx_in,
	input wire logic [3:0] wstrb_in,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] rda_idx_in,
	input wire logic [3:0] rdb_idx_in,
	output logic [31:0] rda_out,
	output logic [31:0] rdb_out
);
	import cmbm_pkg::*;
	cmbm_mem_t m_ff;
	cmbm_mem_t nxt_m;

	always_comb begin
		nxt_m = m_ff;
		if (wr_en_in && wr_idx_in < MEM_WORDS) begin
			for (int k = 0; k < 4; k++) begin
				if (wstrb_in[k]) begin
					nxt_m.word[wr_idx_in][k*8 +: 8] = wdata_in[k*8 +: 8];
				end
			end
		end
		// Reads are combinational so the bus answers one cycle after the address
		rda_out = (rda_idx_in < MEM_WORDS) ? m_ff.word[rda_idx_in] : 32'h0;
		rdb_out = (rdb_idx_in < MEM_WORDS) ? m_ff.word[rdb_idx_in] : 32'h0;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			m_ff <= '0;
		end else if (ce_in) begin
			m_ff <= nxt_m;
		end
	end
endmodule // cmbm_txmem

// ---- rtl/cmbm_local_priority_field_sel.sv ----
/*
 Picks the pending transmit buffer with the lowest local priority value.
 Assumes pending and priority inputs are stable flops of the caller.
*/
`timescale 1ns/10ps
module cmbm_local_priority_field_sel (
	input wire logic [cmbm_pkg::NBUF-1:0] pend_in,
	input wire logic [cmbm_pkg::NBUF-1:0][7:0] local_priority_field_in,
	output logic any_out,
	output logic [1:0] sel_out
);
	import cmbm_pkg::*;

	// Strict compare: equal values go to the lower buffer index
	always_comb begin
		any_out = 1'b0;
		sel_out = 2'h0;
		for (int b = 0; b < NBUF; b++) begin
			if (pend_in[b] && (!any_out || local_priority_field_in[b] < local_priority_field_in[sel_out])) begin
				any_out = 1'b1;
				sel_out = 2'(b);
			end
		end
	end
endmodule // cmbm_local_priority_field_sel

// ---- dv/cmbm_eng_model.sv ----
/*
 Protocol engine model on the engine port of the message buffer manager.
 Assumes the bench calls one task at a time from a single process.
*/
`timescale 1ns/10ps
module cmbm_eng_model (
	input wire logic clk_in,
	input wire cmbm_pkg::cmbm_eng_out_t dut_in,
	output cmbm_pkg::cmbm_eng_in_t eng_out
);
	import cmbm_pkg::*;
	initial begin
		eng_out = '0;
	end
	// ==========================================================
	// Receive: bytes back to back, then end of frame
	task automatic rx_frame(input logic [7:0] base, input logic hit, input logic own);
		for (int k = 0; k < MSG_BYTES; k++) begin
			@(posedge clk_in);
			eng_out.rx_wr <= 1'b1;
			eng_out.rx_idx <= 4'(k);
			eng_out.rx_byte <= base + 8'(k);
		end
		@(posedge clk_in);
		eng_out.rx_wr <= 1'b0;
		// Released data must not keep its last value
		eng_out.rx_byte <= ~eng_out.rx_byte;
		eng_out.rx_end <= 1'b1;
		eng_out.rx_hit <= hit;
		eng_out.rx_own <= own;
		@(posedge clk_in);
		eng_out.rx_end <= 1'b0;
		eng_out.rx_hit <= ~hit;
		eng_out.rx_own <= ~own;
	endtask
	// ==========================================================
	// Transmit: arbitration, byte fetch, outcome
	task automatic arb(output logic [1:0] sel);
		@(posedge clk_in);
		eng_out.arb_start <= 1'b1;
		@(posedge clk_in);
		eng_out.arb_start <= 1'b0;
		@(negedge clk_in);
		sel = dut_in.tx_go ? dut_in.tx_sel : 2'h3;
	endtask
	task automatic get_byte(input logic [3:0] idx, output logic [7:0] b);
		@(posedge clk_in);
		eng_out.tx_idx <= idx;
		@(posedge clk_in);
		@(negedge clk_in);
		b = dut_in.tx_byte;
	endtask
	// Failure stands for an error or a lost arbitration
	task automatic end_tx(input logic ok);
		@(posedge clk_in);
		eng_out.tx_ok <= ok;
		eng_out.tx_fail <= ~ok;
		@(posedge clk_in);
		eng_out.tx_ok <= 1'b0;
		eng_out.tx_fail <= 1'b0;
	endtask
endmodule // cmbm_eng_model

// ---- dv/tb_top.sv ----
/*
 Self-checking bench: register map, receive queue, transmit scheduling, abort.
 Assumes the engine model stands in for the CAN protocol engine.
*/
`timescale 1ns/10ps
module tb_top;
	import cmbm_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	cmbm_axi_req_t req = '0;
	cmbm_axi_rsp_t rsp;
	cmbm_eng_in_t ein;
	cmbm_eng_out_t eout;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [1:0] sel;
	logic [7:0] b;
	always #5 clk_in = ~clk_in;
	cmbm_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .axi_in(req),
		.axi_out(rsp), .eng_in(ein), .eng_out(eout));
	cmbm_eng_model eng (.clk_in(clk_in), .dut_in(eout), .eng_out(ein));
	// ==========================================================
	// Common tasks
	task automatic give_verdict();
		if (errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	// Handshakes are judged at the falling edge, acted on at the next rising
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		logic aw_hs, w_hs, b_hs;
		logic [1:0] r;
		@(posedge clk_in);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(negedge clk_in);
			aw_hs = req.awvalid & rsp.awready;
			w_hs = req.wvalid & rsp.wready;
			b_hs = rsp.bvalid;
			r = rsp.bresp;
			@(posedge clk_in);
			if (aw_hs) req.awvalid <= 1'b0;
			if (w_hs) req.wvalid <= 1'b0;
		end while (b_hs !== 1'b1);
		req.bready <= 1'b0;
		chk(32'(r), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		logic ar_hs, r_hs;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk_in);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(negedge clk_in);
			ar_hs = req.arvalid & rsp.arready;
			r_hs = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge clk_in);
			if (ar_hs) req.arvalid <= 1'b0;
		end while (r_hs !== 1'b1);
		req.rready <= 1'b0;
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask
	// Byte k of a message is base + k, low byte first in each word
	function automatic logic [31:0] fw(input logic [7:0] base, input int w);
		fw = (w == 3) ? {24'h0, base + 8'hc} :
			{base + 8'(4*w+3), base + 8'(4*w+2), base + 8'(4*w+1), base + 8'(4*w)};
	endfunction
	task automatic front(input logic [7:0] base);
		for (int w = 0; w < 4; w++) begin
			rd(A_FRONT + 8'(4*w), fw(base, w));
		end
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rd(A_CTRL, 32'(CTRL_RST));
		rd(A_RXFLG, 32'h0);
		rd(A_TXFLG, 32'(TXE_RST));
		rd(A_TXCTL, 32'h0);
		rd(A_PRIO0 + 8'h8, 32'(LOCAL_PRIORITY_FIELD_RST));
		wr(A_PRIO0 + 8'h4, 32'h5a);
		rd(A_PRIO0 + 8'h4, 32'h5a);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h24, 32'h1, RESP_SLVERR);
	endtask
	task automatic t_rx();
		// Clock enable low freezes everything: the whole frame is lost
		ce_in <= 1'b0;
		eng.rx_frame(8'h70, 1'b1, 1'b0);
		ce_in <= 1'b1;
		rd(A_RXFLG, 32'h0);
		eng.rx_frame(8'h10, 1'b1, 1'b0);
		idle(3);
		chk(32'(eout.rx_irq), 32'h0);
		rd(A_RXFLG, 32'h1);
		front(8'h10);
		wr(A_CTRL, 32'h6);
		idle(2);
		chk(32'(eout.rx_irq), 32'h1);
		// Two more frames back to back: one waits, one overruns
		eng.rx_frame(8'h50, 1'b1, 1'b0);
		eng.rx_frame(8'h90, 1'b1, 1'b0);
		idle(2);
		chk(32'(eout.err_irq), 32'h1);
		rd(A_STAT, 32'h3);
		rd(A_RXFLG, 32'h3);
		front(8'h10);
		wr(A_RXFLG, 32'h0);
		rd(A_RXFLG, 32'h3);
		wr(A_RXFLG, 32'h1);
		idle(1);
		rd(A_RXFLG, 32'h3);
		front(8'h50);
		wr(A_RXFLG, 32'h3);
		rd(A_RXFLG, 32'h0);
		idle(1);
		chk(32'(eout.rx_irq), 32'h0);
		chk(32'(eout.err_irq), 32'h0);
		eng.rx_frame(8'hd0, 1'b0, 1'b0);
		idle(2);
		rd(A_RXFLG, 32'h0);
		eng.rx_frame(8'h20, 1'b1, 1'b1);
		idle(2);
		rd(A_RXFLG, 32'h0);
		wr(A_CTRL, 32'h3);
		eng.rx_frame(8'h20, 1'b1, 1'b1);
		idle(2);
		rd(A_RXFLG, 32'h1);
		front(8'h20);
		wr(A_RXFLG, 32'h1);
		wr(A_CTRL, 32'h0);
	endtask
	task automatic t_tx();
		for (int bf = 0; bf < NBUF; bf++) begin
			for (int w = 0; w < 4; w++) begin
				wr(A_TXBUF + 8'(16*bf + 4*w), fw(8'(32*bf), w));
			end
		end
		wr(A_PRIO0, 32'h30);
		wr(A_PRIO0 + 8'h4, 32'h10);
		wr(A_PRIO0 + 8'h8, 32'h20);
		wr(A_TXFLG, 32'h7);
		wr(A_CTRL, 32'h70);
		idle(2);
		chk(32'(eout.tx_irq), 32'h0);
		chk(32'(eout.tx_pend), 32'h1);
		eng.arb(sel);
		chk(32'(sel), 32'h1);
		chk(32'(eout.ack_allow), 32'h0);
		eng.get_byte(4'hc, b);
		chk(32'(b), 32'h2c);
		eng.end_tx(1'b0);
		eng.arb(sel);
		chk(32'(sel), 32'h1);
		eng.end_tx(1'b1);
		idle(2);
		chk(32'(eout.tx_irq), 32'h1);
		chk(32'(eout.tx_pend), 32'h1);
		rd(A_TXFLG, 32'h2);
		eng.arb(sel);
		chk(32'(sel), 32'h2);
		// Abort one idle buffer and the one on the bus
		wr(A_TXCTL, 32'h5);
		idle(3);
		rd(A_TXFLG, 32'h13);
		eng.end_tx(1'b1);
		idle(2);
		rd(A_TXFLG, 32'h17);
		chk(32'(eout.tx_pend), 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_rx();
		t_tx();
		give_verdict();
	end
endmodule // tb_top
